// file: src/adcif_pkg.sv
// How it works
// [RULE1] Resolutions 8/10 bits, 11/12 average 4/16
// [RULE2] All channels share one result register
// [RULE3] Each start converts every enabled channel
// [RULE4] Start pin fires rising, falling or both
// [RULE5] Sixteen-bit timer makes periodic starts
// [RULE6] Software selects event start with seven
// [RULE7] Several event inputs ORed into one
// [RULE8] Events accepted only when reception enabled
// [RULE9] Event while asleep requests local clock
// [RULE10] Sleep conversion wakes only via interrupt
// [RULE11] Stopped clock halts, resumes afterwards
// [RULE12] Touch mode sequencer drives pad signals
// [RULE13] Two touch drive pins, top and right
// [RULE14] Pen contact and loss detected; contact starts
// [RULE15] One DMA request handshake for results
// [RULE16] One interrupt request output
// [RULE17] Debug halt does not freeze block
// [RULE18] Software disables block before clock gating
// [RULE19] Software idles analog cell before sleep
// [RULE20] Unread result overwritten sets overrun flag
// [RULE21] DMA read clears result ready flag
// [RULE22] Resolution codes 0..3; 8-bit upper bits zero
// [RULE23] Start during sequence is ignored
// [RULE24] Interrupt only for enabled flags, held
package adcif_pkg;
  // Register byte offsets
  localparam logic [7:0] CtrlOff   = 8'h00;
  localparam logic [7:0] CfgOff    = 8'h04;
  localparam logic [7:0] StartOff  = 8'h08;
  localparam logic [7:0] ChanOff   = 8'h0c;
  localparam logic [7:0] ResultOff = 8'h10;
  localparam logic [7:0] StatOff   = 8'h14;
  localparam logic [7:0] IenOff    = 8'h18;
  localparam logic [7:0] IclrOff   = 8'h1c;
  localparam logic [7:0] EvenOff   = 8'h20;
  // Control bits
  localparam int CtrlEnBit    = 0;
  localparam int CtrlStartBit = 1;
  localparam int CtrlTouchBit = 2;
  // Start source codes
  localparam logic [2:0] SrcSoft  = 3'h0;
  localparam logic [2:0] SrcRise  = 3'h1;
  localparam logic [2:0] SrcFall  = 3'h2;
  localparam logic [2:0] SrcAny   = 3'h3;
  localparam logic [2:0] SrcPen   = 3'h4;
  localparam logic [2:0] SrcTimer = 3'h5;
  localparam logic [2:0] SrcCont  = 3'h6;
  localparam logic [2:0] SrcEvent = 3'h7;
  // Start register fields
  localparam int SrcLsb   = 0;
  localparam int TimerLsb = 16;
  // Status bits
  localparam int ReadyBit   = 0;
  localparam int OverrunBit = 1;
  localparam int PenOnBit   = 2;
  localparam int PenOffBit  = 3;
  localparam int BusyBit    = 4;
  // Resolution codes
  localparam logic [1:0] Res8  = 2'h0;
  localparam logic [1:0] Res10 = 2'h1;
  localparam logic [1:0] Res11 = 2'h2;
  localparam logic [1:0] Res12 = 2'h3;
  localparam logic [4:0] Avg11 = 5'h04;
  localparam logic [4:0] Avg12 = 5'h10;
  localparam int NumChan    = 8;
  localparam int NumEvents  = 4;
endpackage

// file: src/adcif_top.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/100ps
module adcif_top (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Clock gating from power manager
  input  wire logic        clkRun,
  output logic             localClkReq,
  output logic             wakeReq,
  // External start pin and events
  input  wire logic        startPin,
  input  wire logic [adcif_pkg::NumEvents-1:0] periphEvent,
  // Pen detect comparator
  input  wire logic        penSense,
  // Analog cell
  output logic             cellStart,
  output logic [2:0]       cellChan,
  input  wire logic        cellDone,
  input  wire logic [9:0]  cellData,
  // Touch panel drive
  output logic             touchDriveTopPin,
  output logic             touchDriveRightPin,
  // DMA handshake
  output logic             dmaReq,
  input  wire logic        dmaAck,
  // Interrupt
  output logic             irq
);
  typedef enum logic [1:0] {Idle, Launch, Wait} adcif_state_t;

  typedef struct packed {
    logic [2:0]  ctrl;
    logic [1:0]  res;
    logic [31:0] startCfg;
    logic [7:0]  chanEn;
    logic [11:0] result;
    logic [3:0]  flags;
    logic [3:0]  ien;
    logic        evEn;
    logic [15:0] timer;
    logic [1:0]  pinSync;
    logic        pinLast;
    logic [1:0]  penSync;
    logic        penLast;
    adcif_state_t st;
    logic [2:0]  chan;
    logic [7:0]  pend;
    logic [4:0]  avgCnt;
    logic [13:0] acc;
    logic        phase;
    logic        asyncRun;
    logic        cellStart;
  } adcif_regs_t;

  adcif_regs_t cur_ff, nxt_cur;

  logic        apbWr;
  logic        apbRd;
  logic        pinRise;
  logic        pinFall;
  logic        penOn;
  logic        penOff;
  logic        evHit;
  logic        trig;
  logic [4:0]  avgN;
  logic [13:0] sum;
  logic [11:0] scaled;
  logic [2:0]  nextChan;
  logic        nextFound;
  logic [3:0]  hwSet;

  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && penable && !pwrite;

  always_comb begin
    nextChan  = 3'h0;
    nextFound = 1'b0;
    for (int i = adcif_pkg::NumChan - 1; i >= 0; i--) begin
      if (cur_ff.pend[i]) begin
        nextChan  = 3'(i);
        nextFound = 1'b1;
      end
    end
  end

  always_comb begin
    nxt_cur = cur_ff;
    // Edges taken only from the second sync stage and its delayed copy
    pinRise = cur_ff.pinSync[1] && !cur_ff.pinLast;
    pinFall = !cur_ff.pinSync[1] && cur_ff.pinLast;
    penOn   = cur_ff.penSync[1] && !cur_ff.penLast;
    penOff  = !cur_ff.penSync[1] && cur_ff.penLast;
    // [RULE7] OR of generators
    // [RULE8] gated by reception enable
    evHit = (|periphEvent) && cur_ff.evEn;
    trig  = 1'b0;
    avgN  = 5'h01;
    sum   = 14'h0000;
    scaled = 12'h000;
    hwSet  = 4'h0;
    // [RULE11] clock stopped: state frozen
    // [RULE17] no debug input stalls the block
    // Event cycle runs on the requested local clock, else the event is lost
    if (clkRun || cur_ff.asyncRun || evHit) begin
      nxt_cur.pinSync = {cur_ff.pinSync[0], startPin};
      nxt_cur.pinLast = cur_ff.pinSync[1];
      nxt_cur.penSync = {cur_ff.penSync[0], penSense};
      nxt_cur.penLast = cur_ff.penSync[1];
      nxt_cur.cellStart = 1'b0;
      // [RULE14] pen contact and loss
      if (penOn) nxt_cur.flags[adcif_pkg::PenOnBit] = 1'b1;
      if (penOff) nxt_cur.flags[adcif_pkg::PenOffBit] = 1'b1;
      hwSet[adcif_pkg::PenOnBit]  = penOn;
      hwSet[adcif_pkg::PenOffBit] = penOff;
      // [RULE5] periodic timer
      if (cur_ff.startCfg[2:0] == adcif_pkg::SrcTimer && cur_ff.ctrl[adcif_pkg::CtrlEnBit]) begin
        if (cur_ff.timer == 16'h0000) begin
          nxt_cur.timer = cur_ff.startCfg[31:16];
        end else begin
          nxt_cur.timer = cur_ff.timer - 16'h0001;
        end
      end else begin
        nxt_cur.timer = cur_ff.startCfg[31:16];
      end
      // [RULE4] edge selection
      unique case (cur_ff.startCfg[2:0])
        adcif_pkg::SrcSoft:  trig = 1'b0;
        adcif_pkg::SrcRise:  trig = pinRise;
        adcif_pkg::SrcFall:  trig = pinFall;
        adcif_pkg::SrcAny:   trig = pinRise || pinFall;
        adcif_pkg::SrcPen:   trig = penOn;
        adcif_pkg::SrcTimer: trig = cur_ff.timer == 16'h0000;
        adcif_pkg::SrcCont:  trig = 1'b1;
        adcif_pkg::SrcEvent: trig = evHit;
      endcase
      if (apbWr && paddr == adcif_pkg::CtrlOff && pwdata[adcif_pkg::CtrlStartBit]) trig = 1'b1;
      trig = trig && cur_ff.ctrl[adcif_pkg::CtrlEnBit];
      // [RULE1] averaging depth
      unique case (cur_ff.res)
        adcif_pkg::Res11: avgN = adcif_pkg::Avg11;
        adcif_pkg::Res12: avgN = adcif_pkg::Avg12;
        default:          avgN = 5'h01;
      endcase
      unique case (cur_ff.st)
        Idle: begin
          // [RULE3] convert all enabled channels
          if (trig && cur_ff.chanEn != 8'h00) begin
            nxt_cur.pend   = cur_ff.chanEn;
            nxt_cur.st     = Launch;
            nxt_cur.avgCnt = 5'h00;
            nxt_cur.acc    = 14'h0000;
            nxt_cur.phase  = 1'b0;
          end
        end
        Launch: begin
          nxt_cur.chan      = nextChan;
          nxt_cur.cellStart = 1'b1;
          nxt_cur.st        = Wait;
        end
        // [RULE23] triggers ignored while busy
        Wait: begin
          if (cellDone) begin
            sum = cur_ff.acc + {4'h0, cellData};
            if (cur_ff.avgCnt + 5'h01 < avgN) begin
              nxt_cur.acc    = sum;
              nxt_cur.avgCnt = cur_ff.avgCnt + 5'h01;
              nxt_cur.st     = Launch;
            end else begin
              // [RULE22] result scaling per resolution
              unique case (cur_ff.res)
                adcif_pkg::Res8:  scaled = {4'h0, cellData[9:2]};
                adcif_pkg::Res10: scaled = {2'h0, cellData};
                adcif_pkg::Res11: scaled = {1'b0, sum[11:1]};
                adcif_pkg::Res12: scaled = sum[13:2];
              endcase
              // [RULE2] one shared result
              nxt_cur.result = scaled;
              // [RULE20] overwrite of unread result
              if (cur_ff.flags[adcif_pkg::ReadyBit]) nxt_cur.flags[adcif_pkg::OverrunBit] = 1'b1;
              nxt_cur.flags[adcif_pkg::ReadyBit] = 1'b1;
              hwSet[adcif_pkg::ReadyBit]   = 1'b1;
              hwSet[adcif_pkg::OverrunBit] = cur_ff.flags[adcif_pkg::ReadyBit];
              nxt_cur.pend[cur_ff.chan] = 1'b0;
              nxt_cur.avgCnt = 5'h00;
              nxt_cur.acc    = 14'h0000;
              // [RULE12] touch pairs: drive phase toggles per channel
              nxt_cur.phase  = !cur_ff.phase;
              nxt_cur.st = (cur_ff.pend & ~(8'h01 << cur_ff.chan)) != 8'h00 ? Launch : Idle;
            end
          end
        end
      endcase
      // [RULE9] hold local clock until sequence ends
      nxt_cur.asyncRun = !clkRun && (evHit || (cur_ff.asyncRun && nxt_cur.st != Idle));
    end
    // Register writes; hardware sets win over clears
    if (apbWr) begin
      unique case (paddr)
        adcif_pkg::CtrlOff:  begin
          nxt_cur.ctrl[adcif_pkg::CtrlEnBit]    = pwdata[adcif_pkg::CtrlEnBit];
          nxt_cur.ctrl[adcif_pkg::CtrlTouchBit] = pwdata[adcif_pkg::CtrlTouchBit];
        end
        adcif_pkg::CfgOff:   nxt_cur.res = pwdata[1:0];
        // [RULE6] code seven selects events
        adcif_pkg::StartOff: nxt_cur.startCfg = pwdata;
        adcif_pkg::ChanOff:  nxt_cur.chanEn = pwdata[7:0];
        adcif_pkg::IenOff:   nxt_cur.ien = pwdata[3:0];
        adcif_pkg::EvenOff:  nxt_cur.evEn = pwdata[0];
        adcif_pkg::IclrOff:  nxt_cur.flags = nxt_cur.flags & ~(pwdata[3:0] & ~hwSet);
        default: ;
      endcase
    end
    // Reading the result clears ready unless a new one lands
    // [RULE21] DMA read clears ready
    if ((dmaAck || (apbRd && paddr == adcif_pkg::ResultOff)) && !hwSet[adcif_pkg::ReadyBit]) begin
      nxt_cur.flags[adcif_pkg::ReadyBit] = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      adcif_pkg::CtrlOff:   prdata = {29'h0, cur_ff.ctrl};
      adcif_pkg::CfgOff:    prdata = {30'h0, cur_ff.res};
      adcif_pkg::StartOff:  prdata = cur_ff.startCfg;
      adcif_pkg::ChanOff:   prdata = {24'h0, cur_ff.chanEn};
      adcif_pkg::ResultOff: prdata = {20'h0, cur_ff.result};
      adcif_pkg::StatOff:   prdata = {27'h0, cur_ff.st != Idle, cur_ff.flags};
      adcif_pkg::IenOff:    prdata = {28'h0, cur_ff.ien};
      adcif_pkg::EvenOff:   prdata = {31'h0, cur_ff.evEn};
      default:              prdata = 32'h0000_0000;
    endcase
  end

  // Zero wait states; unmapped addresses error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr > adcif_pkg::EvenOff || paddr[1:0] != 2'h0);
  assign cellStart = cur_ff.cellStart;
  assign cellChan  = cur_ff.chan;
  // [RULE13] touch drive pins
  assign touchDriveTopPin   = cur_ff.ctrl[adcif_pkg::CtrlTouchBit] && cur_ff.st != Idle && !cur_ff.phase;
  assign touchDriveRightPin = cur_ff.ctrl[adcif_pkg::CtrlTouchBit] && cur_ff.st != Idle && cur_ff.phase;
  // [RULE15] single DMA request
  assign dmaReq = cur_ff.flags[adcif_pkg::ReadyBit];
  // [RULE16] one interrupt line
  // [RULE24] enabled flags only
  assign irq = |(cur_ff.flags & cur_ff.ien);
  // [RULE10] wake only on interrupt
  assign wakeReq = irq && !clkRun;
  assign localClkReq = cur_ff.asyncRun || (!clkRun && evHit);

  overrun_set_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE20]
    (cur_ff.st == Wait && cellDone && cur_ff.flags[0] && cur_ff.avgCnt + 5'h01 >= avgN && clkRun)
    |=> cur_ff.flags[1]) else $error("Overrun not set");
  irq_gate_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE24]
    (irq && !apbWr && !apbRd && !dmaAck) |=> irq) else $error("Irq dropped without clear");
  res8_zero_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE22]
    (cur_ff.res == 2'h0 && $changed(cur_ff.result)) |-> cur_ff.result[11:8] == 4'h0)
    else $error("8-bit result has upper bits");
  busy_hold_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE23]
    (cur_ff.st == Wait && !cellDone) |=> cur_ff.st == Wait) else $error("Sequence restarted");
  freeze_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE11]
    (!clkRun && !localClkReq && !apbWr && !apbRd && !dmaAck) |=> $stable(cur_ff.st))
    else $error("State moved while stopped");
  dma_clear_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE21]
    (dmaAck && !cellDone) |=> !cur_ff.flags[0]) else $error("Ready not cleared by DMA");
  event_gate_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE8]
    (cur_ff.st == Idle && !cur_ff.evEn && cur_ff.startCfg[2:0] == 3'h7 && !apbWr)
    |=> cur_ff.st == Idle) else $error("Event accepted while disabled");
  touch_excl_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE13]
    !(touchDriveTopPin && touchDriveRightPin)) else $error("Both drives on");
  touch_swap_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE12]
    (touchDriveTopPin && cur_ff.st == Wait && cellDone && cur_ff.avgCnt + 5'h01 >= avgN
    && clkRun) |=> !touchDriveTopPin) else $error("Top drive kept after channel");
  launch_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE3]
    (cur_ff.st == Launch && clkRun) |=> cellStart && cur_ff.chanEn[cellChan])
    else $error("Launch without enabled channel");
endmodule

// file: verif/adcif_cell_model.sv
`timescale 1ns/100ps
module adcif_cell_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Answer speed
  input  wire logic       slowMode,
  // Converter handshake
  input  wire logic       cellStart,
  input  wire logic [2:0] cellChan,
  output logic            cellDone,
  output logic [9:0]      cellData
);
  logic [4:0] waitCnt;
  logic [9:0] lastData;
  logic [2:0] chan;
  // Code depends on channel only, so averaged results are predictable
  always @(posedge core_clk) begin
    cellDone <= 1'h0;
    // Data is not held outside the done pulse
    cellData <= ~lastData;
    if (rst) begin
      waitCnt  <= 5'h00;
      lastData <= 10'h000;
    end else if (cellStart) begin
      chan    <= cellChan;
      waitCnt <= slowMode ? 5'h0c : 5'h02;
    end else if (waitCnt == 5'h01) begin
      cellDone <= 1'h1;
      cellData <= {chan, 7'h5a};
      lastData <= {chan, 7'h5a};
      waitCnt  <= 5'h00;
    end else if (waitCnt != 5'h00) begin
      waitCnt <= waitCnt - 5'h01;
    end
  end
endmodule

// file: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, clkRun, lastErr;
  logic        localClkReq, wakeReq, startPin, penSense, cellStart, cellDone, slowMode;
  logic        touchDriveTopPin, touchDriveRightPin, dmaReq, dmaAck, irq, topSeen, rightSeen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  periphEvent;
  logic [2:0]  cellChan;
  logic [9:0]  cellData;
  logic [3:0]  evTab [5] = '{4'h1, 4'h1, 4'h2, 4'h8, 4'hf};
  int          miscompares, nChecks, nStarts, n0, k;

  adcif_top i_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .clkRun, .localClkReq, .wakeReq, .startPin, .periphEvent, .penSense,
    .cellStart, .cellChan, .cellDone, .cellData, .touchDriveTopPin, .touchDriveRightPin,
    .dmaReq, .dmaAck, .irq);
  adcif_cell_model i_cell (.core_clk, .rst, .slowMode, .cellStart, .cellChan, .cellDone,
    .cellData);

  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    nStarts += (cellStart === 1'h1);
    topSeen |= (touchDriveTopPin === 1'h1);
    rightSeen |= (touchDriveRightPin === 1'h1);
  end

  task automatic finish_test;
    $display("checks %0d miscompares %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    q = prdata;
    lastErr = pslverr;
    if (n >= 50) miscompares++;
    psel <= 1'h0;
    penable <= 1'h0;
    // Idle edge so a following call never re-drives psel in the same step
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask

  // Pin triggers need a few cycles of sync before busy shows
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (8) @(posedge core_clk);
    do begin
      rd(8'h14);
      n++;
    end while (q[4] !== 1'h0 && n < 200);
    if (n >= 200) miscompares++;
  endtask

  function automatic logic [31:0] exp_res(input int r, input logic [2:0] ch);
    logic [9:0] d;
    d = {ch, 7'h5a};
    case (r)
      0: return {24'h0, d[9:2]};
      1: return {22'h0, d};
      2: return {21'h0, d, 1'h0};
      default: return {20'h0, d, 2'h0};
    endcase
  endfunction

  initial begin
    {psel, penable, pwrite, startPin, penSense, dmaAck, slowMode} = 7'h00;
    {topSeen, rightSeen, rst, clkRun} = 4'h3;
    paddr = 8'h00;
    pwdata = 32'h0;
    periphEvent = 4'h0;
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    rd(8'h14);
    check("reset status", q, 32'h0);
    rd(8'h40);
    check("unmapped", {q[30:0], lastErr}, 32'h1);
    wr(8'h00, 32'h1);
    wr(8'h0c, 32'h4);
    for (int r = 0; r < 4; r++) begin
      wr(8'h04, 32'(r));
      n0 = nStarts;
      wr(8'h00, 32'h3);
      wait_idle();
      check("irq masked", {31'h0, irq}, 32'h0);
      check("samples", nStarts - n0, (r < 2) ? 1 : (r == 2 ? 4 : 16));
      rd(8'h10);
      check("result", q, exp_res(r, 3'h2));
    end
    wr(8'h04, 32'h1);
    wr(8'h0c, 32'ha);
    n0 = nStarts;
    wr(8'h00, 32'h3);
    wait_idle();
    check("channels", nStarts - n0, 32'h2);
    check("overrun", q, 32'h3);
    rd(8'h10);
    check("shared", q, exp_res(1, 3'h3));
    wr(8'h1c, 32'hf);
    wr(8'h0c, 32'h4);
    wr(8'h18, 32'h1);
    wr(8'h00, 32'h3);
    wait_idle();
    repeat (5) @(posedge core_clk);
    check("irq dma", {30'h0, irq, dmaReq}, 32'h3);
    dmaAck <= 1'h1;
    @(posedge core_clk);
    dmaAck <= 1'h0;
    @(posedge core_clk);
    check("dma ack", {30'h0, irq, dmaReq}, 32'h0);
    slowMode <= 1'h1;
    n0 = nStarts;
    wr(8'h00, 32'h3);
    repeat (2) @(posedge core_clk);
    wr(8'h00, 32'h3);
    wait_idle();
    check("restart", nStarts - n0, 32'h1);
    for (int m = 1; m < 4; m++) begin
      wr(8'h08, 32'(m));
      for (int e = 0; e < 2; e++) begin
        n0 = nStarts;
        startPin <= ~startPin;
        wait_idle();
        check("pin", nStarts - n0, 32'(m == 3 || m == e + 1));
      end
    end
    wr(8'h08, 32'h7);
    for (k = 0; k < 5; k++) begin
      wr(8'h20, {31'h0, k != 0});
      n0 = nStarts;
      periphEvent <= evTab[k];
      @(posedge core_clk);
      periphEvent <= 4'h0;
      wait_idle();
      check("event", nStarts - n0, 32'(k != 0));
    end
    wr(8'h1c, 32'hf);
    clkRun <= 1'h0;
    periphEvent <= 4'h1;
    @(posedge core_clk);
    periphEvent <= 4'h0;
    for (k = 0; k < 40 && localClkReq !== 1'h1; k++) @(posedge core_clk);
    check("clk req", {30'h0, localClkReq, wakeReq}, 32'h2);
    for (k = 0; k < 300 && localClkReq !== 1'h0; k++) @(posedge core_clk);
    check("clk free", {30'h0, localClkReq, wakeReq}, 32'h1);
    clkRun <= 1'h1;
    wr(8'h08, 32'h00270005);
    n0 = nStarts;
    repeat (400) @(posedge core_clk);
    wr(8'h08, 32'h0);
    wait_idle();
    check("timer", 32'(nStarts - n0 >= 9 && nStarts - n0 <= 11), 32'h1);
    wr(8'h0c, 32'h3);
    wr(8'h00, 32'h5);
    {topSeen, rightSeen} = 2'h0;
    wr(8'h00, 32'h7);
    wait_idle();
    check("touch", {30'h0, topSeen, rightSeen}, 32'h3);
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h4);
    n0 = nStarts;
    penSense <= 1'h1;
    wait_idle();
    check("pen start", nStarts - n0, 32'h2);
    check("pen on", {31'h0, q[2]}, 32'h1);
    penSense <= 1'h0;
    repeat (8) @(posedge core_clk);
    rd(8'h14);
    check("pen off", {31'h0, q[3]}, 32'h1);
    wr(8'h00, 32'h0);
    clkRun <= 1'h0;
    wr(8'h00, 32'h2);
    rd(8'h14);
    check("disabled", {31'h0, q[4]}, 32'h0);
    finish_test();
  end

  initial begin
    repeat (30000) @(posedge core_clk);
    miscompares++;
    finish_test();
  end
endmodule
